// ---- bench/jvpw_codec_asserts.sv ----
// Purpose: Port-level checks of the VPW codec.
// Assumes: ce held high by the bench.
// Notes:   Bound to every jvpw_codec instance.
`timescale 1ns/1ps
module jvpw_codec_asserts #(
  parameter int AW = 8
) (
  input wire logic          clk,
  input wire logic          rst_b,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          busTxOut
);
  logic mapped;
  assign mapped = paddr[7:0] inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_acc; psel && penable && !pready; endsequence
  sequence s_hi8; busTxOut [*8]; endsequence
  sequence s_lo8; !busTxOut [*8]; endsequence
  property p_rdy_time; s_acc |=> pready; endproperty
  property p_rdy_pulse; pready |=> !pready; endproperty
  property p_rdy_cause; pready |-> $past(psel && penable); endproperty
  property p_err_map; pready && !mapped |-> pslverr && prdata == 32'h0; endproperty
  property p_ok_map; pready && mapped |-> !pslverr; endproperty
  property p_err_solo; !pready |-> !pslverr; endproperty
  property p_tx_rst; $rose(rst_b) |-> !busTxOut; endproperty
  property p_tx_hold; $rose(busTxOut) |=> s_hi8; endproperty
  property p_tx_rest; $fell(busTxOut) |=> s_lo8; endproperty
  a_rdy_time:  assert property (p_rdy_time)  else $error("late ready");
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready too long");
  a_rdy_cause: assert property (p_rdy_cause) else $error("ready without access");
  a_err_map:   assert property (p_err_map)   else $error("unmapped not refused");
  a_ok_map:    assert property (p_ok_map)    else $error("mapped refused");
  a_err_solo:  assert property (p_err_solo)  else $error("error without ready");
  a_tx_rst:    assert property (p_tx_rst)    else $error("tx active after reset");
  a_tx_hold:   assert property (p_tx_hold)   else $error("active level too short");
  a_tx_rest:   assert property (p_tx_rest)   else $error("passive level too short");
endmodule : jvpw_codec_asserts

bind jvpw_codec jvpw_codec_asserts #(.AW(AW)) uChk (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .busTxOut(busTxOut));

// ---- bench/jvpw_codec_tb_top.sv ----
// Purpose: Self-checking bench of the VPW codec.
// Assumes: Prescale 0, one tick per clock.
// Notes:   Pin widths allow two clocks of slack.
`timescale 1ns/1ps
module jvpw_codec_tb_top;
  logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdQ;
  logic        pready, pslverr, busRxIn, busTxOut, errQ;
  logic        otherNode = 1'b0, rxInv = 1'b0, hi;
  logic [4:0]  loopDly = 5'h00;
  int          mismatches = 0, checks = 0;
  int          wq;
  localparam logic [7:0] IFR_BYTE = 8'h3c;
  always #2.5 clk = ~clk;
  jvpw_codec DUT (.clk(clk), .rst_b(rst_b), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busRxIn(busRxIn), .busTxOut(busTxOut));
  jvpw_xcvr_model uXcvr (.clk(clk), .txPin(busTxOut), .otherNode(otherNode),
    .invert(rxInv), .delay(loopDly), .rxPin(busRxIn));
  task automatic report_and_stop;
    if (mismatches == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chkw(input int got, input int exp);
    checks++;
    if (got < exp - 2 || got > exp + 2) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkw
  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask : waitc
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No local limit: only the watchdog ends a stuck access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdQ = prdata;
    errQ = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic waitTx(input logic lvl);
    while (busTxOut !== lvl) begin
      @(posedge clk);
    end
  endtask : waitTx
  task automatic meas(output int w);
    logic lvl;
    w = 0;
    lvl = busTxOut;
    while (busTxOut === lvl) begin
      @(posedge clk);
      w++;
    end
  endtask : meas
  function automatic logic [7:0] crc8(input logic [7:0] b);
    logic [7:0] c;
    c = jvpw_pkg::CRC_INIT ^ b;
    repeat (8) c = c[7] ? ((c << 1) ^ jvpw_pkg::CRC_POLY) : (c << 1);
    return ~c;
  endfunction : crc8
  task automatic frame(input logic [7:0] b, input logic [4:0] d, input logic inv);
    logic [15:0] bits;
    int          w;
    bits = {b, crc8(b)};
    apb(1'b1, jvpw_pkg::OFF_CTRL, {24'h0, d, 1'b0, inv, 1'b1});
    loopDly <= d;
    rxInv <= inv;
    waitc(20);
    apb(1'b0, jvpw_pkg::OFF_CTRL, 32'h0);
    chk(rdQ, {24'h0, d, 1'b0, inv, 1'b1});
    apb(1'b1, jvpw_pkg::OFF_TXDATA, {23'h0, 1'b1, b});
    waitTx(1'b1);
    meas(w);
    chkw(w, 200);
    for (int i = 15; i >= 0; i--) begin
      meas(w);
      chkw(w, (bits[i] ^ !i[0]) ? 128 : 64);
    end
    waitc(300);
    chk({31'h0, busTxOut}, 32'h0);
    apb(1'b0, jvpw_pkg::OFF_RXDATA, 32'h0);
    chk(rdQ & 32'hff, {24'h0, bits[7:0]});
  endtask : frame
  task automatic pulse(input int n);
    otherNode <= 1'b1;
    waitc(n);
    otherNode <= 1'b0;
    waitc(40);
    apb(1'b0, jvpw_pkg::OFF_STATUS, 32'h0);
  endtask : pulse
  initial begin
    #100000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    waitc(8);
    rst_b <= 1'b1;
    apb(1'b0, jvpw_pkg::OFF_CTRL, 32'h0);
    chk(rdQ, 32'h0);
    apb(1'b0, jvpw_pkg::OFF_FILTER, 32'h0);
    chk(rdQ, jvpw_pkg::FILTER_RST);
    apb(1'b0, jvpw_pkg::OFF_STATUS, 32'h0);
    chk(rdQ, 32'h18);
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, errQ}, 32'h1);
    frame(8'h5a, 5'h00, 1'b0);
    frame(8'ha5, 5'h14, 1'b1);
    pulse(5);
    chk(rdQ & 32'h2, 32'h0);
    pulse(20);
    chk(rdQ & 32'h42, 32'h42);
    waitc(300);
    apb(1'b0, jvpw_pkg::OFF_STATUS, 32'h0);
    chk(rdQ & 32'h40, 32'h0);
    apb(1'b1, jvpw_pkg::OFF_STATUS, 32'h2);
    apb(1'b0, jvpw_pkg::OFF_STATUS, 32'h0);
    chk(rdQ & 32'h2, 32'h0);
    // Lose a passive one bit to a node going active
    apb(1'b1, jvpw_pkg::OFF_TXDATA, 32'h180);
    waitTx(1'b1);
    waitTx(1'b0);
    // Late enough that the echoed passive level is a bit, not an invalid pulse
    waitc(60);
    otherNode <= 1'b1;
    hi = 1'b0;
    for (int i = 0; i < 200; i++) begin
      @(posedge clk);
      hi = hi | busTxOut;
      if (i == 64) otherNode <= 1'b0;
    end
    chk({31'h0, hi}, 32'h0);
    apb(1'b0, jvpw_pkg::OFF_STATUS, 32'h0);
    chk(rdQ & 32'h4, 32'h4);
    apb(1'b1, jvpw_pkg::OFF_FILTER, 32'h0);
    apb(1'b0, jvpw_pkg::OFF_FILTER, 32'h0);
    chk(rdQ, 32'h0);
    // Masked message with a type 1 response queued behind it
    apb(1'b1, jvpw_pkg::OFF_TXDATA, 32'h133);
    waitTx(1'b1);
    apb(1'b1, jvpw_pkg::OFF_TXDATA, {21'h0, 2'b01, 1'b1, IFR_BYTE});
    repeat (18) meas(wq);
    meas(wq);
    chkw(wq, 64);
    for (int i = 7; i >= 0; i--) begin
      meas(wq);
      chkw(wq, (IFR_BYTE[i] ^ !i[0]) ? 128 : 64);
    end
    waitc(300);
    chk({31'h0, busTxOut}, 32'h0);
    apb(1'b0, jvpw_pkg::OFF_STATUS, 32'h0);
    chk(rdQ & 32'h1, 32'h0);
    report_and_stop();
  end
endmodule : jvpw_codec_tb_top

// ---- bench/jvpw_xcvr_model.sv ----
// Purpose: Transceiver and bus seen from the codec pins.
// Assumes: Loop delay in whole clocks, up to 31.
// Notes:   Another node may pull the bus active.
`timescale 1ns/1ps
module jvpw_xcvr_model (
  input  wire logic       clk,
  input  wire logic       txPin,
  input  wire logic       otherNode,
  input  wire logic       invert,
  input  wire logic [4:0] delay,
  output logic            rxPin
);
  logic [31:0] lineQ;
  logic        busLvl;
  always_ff @(posedge clk) begin
    lineQ <= {lineQ[30:0], txPin};
  end
  // Wired-or: active wins, so ones dominate
  assign busLvl = ((delay == 5'h00) ? txPin : lineQ[delay - 5'h01]) | otherNode;
  assign rxPin  = busLvl ^ invert;
endmodule : jvpw_xcvr_model

// ---- include/jvpw_pkg.sv ----
// Purpose: Shared constants and types of the VPW symbol codec.
// Assumes: Durations are counted in prescaled ticks.
// Notes:   Register offsets are byte addresses on APB.
package jvpw_pkg;

  // Duration thresholds, in ticks (classification upper bounds)
  localparam logic [8:0] IGN_MAX = 9'h007;
  localparam logic [8:0] INV_MAX = 9'h022;
  localparam logic [8:0] TV1_MAX = 9'h060;
  localparam logic [8:0] TV2_MAX = 9'h0a3;
  localparam logic [8:0] TV3_MAX = 9'h0ef;
  localparam logic [8:0] TV4_MAX = 9'h118;
  localparam logic [8:0] DUR_SAT = 9'h1ff;

  // Nominal transmit lengths, in ticks
  localparam logic [8:0] TV1_NOM = 9'h040;
  localparam logic [8:0] TV2_NOM = 9'h080;
  localparam logic [8:0] TV3_NOM = 9'h0c8;
  localparam logic [8:0] TV4_NOM = 9'h118;
  localparam logic [8:0] TV5_NOM = 9'h12c;

  // Digital filter length: a level must hold this many ticks
  localparam logic [3:0] FILT_LEN = 4'h8;

  // Register offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_TXDATA = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_RXDATA = 8'h0c;
  localparam logic [7:0] OFF_FILTER = 8'h10;

  // Control fields
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_INV_BIT = 1;
  localparam int CTRL_NB_BIT  = 2;
  localparam int CTRL_DLY_LSB = 3;
  localparam int CTRL_PS_LSB  = 8;
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [31:0] FILTER_RST = 32'hffffffff;

  // Transmit data fields
  localparam int TXD_LAST_BIT = 8;
  localparam int TXD_TYPE_LSB = 9;

  // Status bits
  localparam int ST_RXFULL  = 0;
  localparam int ST_INVALID = 1;
  localparam int ST_LOSTARB = 2;
  localparam int ST_TXEMPTY = 3;
  localparam int ST_IDLE    = 4;
  localparam int ST_TXBUSY  = 5;
  localparam int ST_SUPPR   = 6;

  // Frame check
  localparam logic [7:0] CRC_POLY = 8'h1d;
  localparam logic [7:0] CRC_INIT = 8'hff;

  typedef enum logic [3:0] {
    SK_IGN = 4'b0000,
    SK_INV = 4'b0001,
    SK_BIT0 = 4'b0010,
    SK_BIT1 = 4'b0011,
    SK_SOF = 4'b0100,
    SK_EOD = 4'b0101,
    SK_EOF = 4'b0110,
    SK_BRK = 4'b0111,
    SK_IFS = 4'b1000
  } jvpw_sym_t;

  typedef enum logic [1:0] {
    T_IDLE = 2'b00,
    T_SYNC = 2'b01,
    T_HOLD = 2'b10
  } jvpw_tx_state_t;

  typedef enum logic [1:0] {
    K_SOF = 2'b00,
    K_NB  = 2'b01,
    K_BIT = 2'b10,
    K_END = 2'b11
  } jvpw_tx_kind_t;

endpackage : jvpw_pkg

// ---- logic/jvpw_classify.sv ----
// Purpose: Turns a measured level length and its level into a symbol class.
// Assumes: dur is the tick count of the level that just ended.
// Notes:   Purely combinational.
`timescale 1ns/1ps
module jvpw_classify (
  input  wire logic [8:0]       dur,
  input  wire logic             lvlActive,
  output jvpw_pkg::jvpw_sym_t   symbol
);

  always_comb begin
    if (dur <= jvpw_pkg::IGN_MAX) begin
      symbol = jvpw_pkg::SK_IGN;
    end else if (dur <= jvpw_pkg::INV_MAX) begin
      symbol = jvpw_pkg::SK_INV;
    end else if (dur <= jvpw_pkg::TV1_MAX) begin
      symbol = lvlActive ? jvpw_pkg::SK_BIT1 : jvpw_pkg::SK_BIT0;
    end else if (dur <= jvpw_pkg::TV2_MAX) begin
      symbol = lvlActive ? jvpw_pkg::SK_BIT0 : jvpw_pkg::SK_BIT1;
    end else if (dur <= jvpw_pkg::TV3_MAX) begin
      symbol = lvlActive ? jvpw_pkg::SK_SOF : jvpw_pkg::SK_EOD;
    end else if (lvlActive) begin
      symbol = jvpw_pkg::SK_BRK;
    end else if (dur <= jvpw_pkg::TV4_MAX) begin
      symbol = jvpw_pkg::SK_EOF;
    end else begin
      symbol = jvpw_pkg::SK_IFS;
    end
  end

endmodule : jvpw_classify

// ---- logic/jvpw_codec.sv ----
// Purpose: VPW symbol encoder and decoder with an APB register slave.
// Assumes: busRxIn is synchronous to clk; the transceiver loops tx back to rx.
// Notes:   Ticks come from a prescaler so thresholds map to microseconds.
`timescale 1ns/1ps
module jvpw_codec #(
  parameter int AW = 8
) (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          ce,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          busRxIn,
  output logic               busTxOut
);

  typedef struct packed {
    logic [15:0]              ctrl;
    logic [31:0]              acceptMask;
    logic [31:0]              prdata;
    logic                     pready;
    logic                     pslverr;
    logic [7:0]               psCnt;
    logic                     tick;
    logic [8:0]               rxCnt;
    logic [7:0]               rxShift;
    logic [2:0]               rxBits;
    logic                     rxFirst;
    logic                     rxAccept;
    logic                     inFrame;
    logic                     afterEod;
    logic                     busIdle;
    logic                     suppress;
    logic [7:0]               rxData;
    logic                     rxFullFlag;
    logic                     invalidBitFlag;
    logic                     lostArb;
    logic [7:0]               bufData;
    logic                     bufLast;
    logic [1:0]               bufType;
    logic                     bufFull;
    jvpw_pkg::jvpw_tx_state_t txState;
    jvpw_pkg::jvpw_tx_kind_t  txKind;
    logic [7:0]               txShift;
    logic [2:0]               txBits;
    logic [7:0]               txCrc;
    logic                     txCrcPhase;
    logic                     txLast;
    logic [1:0]               txType;
    logic                     busTxOut;
  } jvpw_codec_state_t;

  jvpw_codec_state_t   s_q;
  jvpw_codec_state_t   s_d;
  logic                filtLevel;
  logic                filtEdge;
  logic [8:0]          durNext;
  jvpw_pkg::jvpw_sym_t symClass;
  logic [8:0]          holdNom;
  logic [8:0]          holdDelay;
  logic [8:0]          holdTarget;
  logic [7:0]          rxByte;
  logic                rxAcc;
  logic                txBit;
  logic                crcWanted;
  logic                abortTx;
  logic                apbDone;
  logic [4:0]          loopDelayField;

  function automatic logic [7:0] crcStep(input logic [7:0] c, input logic b);
    logic fb;
    fb = c[7] ^ b;
    return {c[6:0], 1'b0} ^ (fb ? jvpw_pkg::CRC_POLY : 8'h00);
  endfunction : crcStep

  function automatic logic [8:0] symNominal(input jvpw_pkg::jvpw_tx_kind_t k,
                                            input logic act, input logic b,
                                            input logic nbLong);
    case (k)
      jvpw_pkg::K_SOF: return jvpw_pkg::TV3_NOM;
      jvpw_pkg::K_NB:  return nbLong ? jvpw_pkg::TV2_NOM : jvpw_pkg::TV1_NOM;
      jvpw_pkg::K_BIT: return (act ^ b) ? jvpw_pkg::TV2_NOM : jvpw_pkg::TV1_NOM;
      default:         return jvpw_pkg::TV3_NOM;
    endcase
  endfunction : symNominal

  jvpw_filter u_filter (
    .clk       (clk),
    .rst_b     (rst_b),
    .ce        (ce),
    .tick      (s_q.tick),
    .rawIn     (busRxIn),
    .invert    (s_q.ctrl[jvpw_pkg::CTRL_INV_BIT]),
    .level     (filtLevel),
    .edgePulse (filtEdge)
  );

  // Level that just ended is the opposite of the new filtered level
  jvpw_classify u_classify (
    .dur       (durNext),
    .lvlActive (~filtLevel),
    .symbol    (symClass)
  );

  always_comb begin
    s_d = s_q;
    abortTx = 1'b0;
    loopDelayField = s_q.ctrl[jvpw_pkg::CTRL_DLY_LSB +: 5];
    apbDone = psel && penable && s_q.pready;
    durNext = (s_q.rxCnt == jvpw_pkg::DUR_SAT) ? jvpw_pkg::DUR_SAT : s_q.rxCnt + 9'h001;
    rxByte = {s_q.rxShift[6:0], symClass == jvpw_pkg::SK_BIT1};
    rxAcc = s_q.rxFirst ? s_q.acceptMask[rxByte[7:3]] : s_q.rxAccept;
    txBit = s_q.txShift[7];
    crcWanted = (s_q.txType == 2'b00) || (s_q.txType == 2'b11);
    holdNom = symNominal(s_q.txKind, s_q.busTxOut, txBit, s_q.ctrl[jvpw_pkg::CTRL_NB_BIT]);
    holdDelay = {4'h0, loopDelayField} + {5'h00, jvpw_pkg::FILT_LEN};
    holdTarget = (holdNom > holdDelay) ? holdNom - holdDelay : 9'h001;

    // APB slave: one wait state, answers registered
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    if (psel && penable && !s_q.pready) begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h00000000;
      case (paddr[7:0])
        jvpw_pkg::OFF_CTRL:   s_d.prdata = {16'h0000, s_q.ctrl};
        jvpw_pkg::OFF_TXDATA: s_d.prdata = {21'h000000, s_q.bufType, s_q.bufLast, s_q.bufData};
        jvpw_pkg::OFF_STATUS: s_d.prdata = {25'h0000000, s_q.suppress,
                                            s_q.txState != jvpw_pkg::T_IDLE, s_q.busIdle,
                                            ~s_q.bufFull, s_q.lostArb, s_q.invalidBitFlag,
                                            s_q.rxFullFlag};
        jvpw_pkg::OFF_RXDATA: s_d.prdata = {24'h000000, s_q.rxData};
        jvpw_pkg::OFF_FILTER: s_d.prdata = s_q.acceptMask;
        default:              s_d.pslverr = 1'b1;
      endcase
    end
    if (apbDone && pwrite) begin
      case (paddr[7:0])
        jvpw_pkg::OFF_CTRL: s_d.ctrl = pwdata[15:0];
        jvpw_pkg::OFF_TXDATA: begin
          // A write into a full buffer is dropped; poll the empty bit first
          if (!s_q.bufFull) begin
            s_d.bufData = pwdata[7:0];
            s_d.bufLast = pwdata[jvpw_pkg::TXD_LAST_BIT];
            s_d.bufType = pwdata[jvpw_pkg::TXD_TYPE_LSB +: 2];
            s_d.bufFull = 1'b1;
          end
        end
        jvpw_pkg::OFF_STATUS: begin
          if (pwdata[jvpw_pkg::ST_INVALID]) s_d.invalidBitFlag = 1'b0;
          if (pwdata[jvpw_pkg::ST_LOSTARB]) s_d.lostArb = 1'b0;
        end
        jvpw_pkg::OFF_FILTER: s_d.acceptMask = pwdata;
        default: ;
      endcase
    end
    if (apbDone && !pwrite && paddr[7:0] == jvpw_pkg::OFF_RXDATA) begin
      s_d.rxFullFlag = 1'b0;
    end

    // Prescaled time base
    s_d.tick = 1'b0;
    if (s_q.psCnt == s_q.ctrl[jvpw_pkg::CTRL_PS_LSB +: 8]) begin
      s_d.psCnt = 8'h00;
      s_d.tick = s_q.ctrl[jvpw_pkg::CTRL_EN_BIT];
    end else begin
      s_d.psCnt = s_q.psCnt + 8'h01;
    end

    // Decoder: every filtered edge ends one symbol
    if (filtEdge) begin
      s_d.rxCnt = 9'h000;
      s_d.busIdle = 1'b0;
      case (symClass)
        jvpw_pkg::SK_INV: begin
          s_d.invalidBitFlag = 1'b1;
          s_d.suppress = 1'b1;
          s_d.inFrame = 1'b0;
          abortTx = 1'b1;
        end
        jvpw_pkg::SK_SOF: begin
          s_d.inFrame = 1'b1;
          s_d.rxBits = 3'h0;
          s_d.rxFirst = 1'b1;
          s_d.afterEod = 1'b0;
        end
        jvpw_pkg::SK_BIT0, jvpw_pkg::SK_BIT1: begin
          if (s_q.afterEod && !filtLevel) begin
            s_d.afterEod = 1'b0;
          end else if (s_q.inFrame) begin
            s_d.rxShift = rxByte;
            s_d.rxBits = s_q.rxBits + 3'h1;
            if (s_q.rxBits == 3'h7) begin
              s_d.rxFirst = 1'b0;
              s_d.rxAccept = rxAcc;
              if (rxAcc && !s_q.suppress) begin
                s_d.rxData = rxByte;
                s_d.rxFullFlag = 1'b1;
              end
            end
          end
        end
        jvpw_pkg::SK_BRK: begin
          s_d.inFrame = 1'b0;
          s_d.afterEod = 1'b0;
        end
        default: ;
      endcase
    end else if (s_q.tick) begin
      s_d.rxCnt = durNext;
      if (!filtLevel) begin
        if (durNext == jvpw_pkg::TV2_MAX + 9'h001 && s_q.inFrame) begin
          s_d.afterEod = 1'b1;
          s_d.rxBits = 3'h0;
        end
        if (durNext == jvpw_pkg::TV3_MAX + 9'h001) begin
          s_d.inFrame = 1'b0;
          s_d.afterEod = 1'b0;
          s_d.suppress = 1'b0;
        end
        if (durNext == jvpw_pkg::TV4_MAX + 9'h001) begin
          s_d.busIdle = 1'b1;
        end
      end
    end

    // Encoder
    case (s_q.txState)
      jvpw_pkg::T_IDLE: begin
        s_d.busTxOut = 1'b0;
        if (s_q.bufFull && s_q.tick &&
            ((s_q.bufType == 2'b00) ? s_q.busIdle : s_q.afterEod)) begin
          s_d.txShift = s_q.bufData;
          s_d.txLast = s_q.bufLast;
          s_d.txType = s_q.bufType;
          s_d.bufFull = 1'b0;
          s_d.txCrc = jvpw_pkg::CRC_INIT;
          s_d.txCrcPhase = 1'b0;
          s_d.txBits = 3'h0;
          s_d.txKind = (s_q.bufType == 2'b00) ? jvpw_pkg::K_SOF : jvpw_pkg::K_NB;
          s_d.busTxOut = 1'b1;
          s_d.txState = jvpw_pkg::T_SYNC;
        end
      end
      jvpw_pkg::T_SYNC: begin
        // Already-matching level still times from the decoder counter
        if (filtLevel == s_q.busTxOut) begin
          s_d.txState = jvpw_pkg::T_HOLD;
        end
      end
      jvpw_pkg::T_HOLD: begin
        if (s_q.txKind == jvpw_pkg::K_BIT && !s_q.busTxOut && filtEdge && filtLevel) begin
          s_d.busTxOut = 1'b0;
          s_d.lostArb = 1'b1;
          s_d.txState = jvpw_pkg::T_IDLE;
        end else if (s_q.tick && s_q.rxCnt >= holdTarget) begin
          s_d.txState = jvpw_pkg::T_SYNC;
          s_d.busTxOut = ~s_q.busTxOut;
          case (s_q.txKind)
            jvpw_pkg::K_SOF, jvpw_pkg::K_NB: s_d.txKind = jvpw_pkg::K_BIT;
            jvpw_pkg::K_BIT: begin
              if (!s_q.txCrcPhase) s_d.txCrc = crcStep(s_q.txCrc, txBit);
              s_d.txShift = {s_q.txShift[6:0], 1'b0};
              s_d.txBits = s_q.txBits + 3'h1;
              if (s_q.txBits == 3'h7) begin
                if (s_q.txCrcPhase || (s_q.txLast && !crcWanted)) begin
                  s_d.txKind = jvpw_pkg::K_END;
                end else if (s_q.txLast) begin
                  s_d.txShift = ~crcStep(s_q.txCrc, txBit);
                  s_d.txCrcPhase = 1'b1;
                end else if (s_q.bufFull) begin
                  s_d.txShift = s_q.bufData;
                  s_d.txLast = s_q.bufLast;
                  s_d.bufFull = 1'b0;
                end else begin
                  // Underrun ends the frame without a check byte
                  s_d.busTxOut = 1'b0;
                  s_d.txState = jvpw_pkg::T_IDLE;
                end
              end
            end
            default: begin
              s_d.busTxOut = s_q.busTxOut;
              s_d.txState = jvpw_pkg::T_IDLE;
            end
          endcase
        end
      end
      default: s_d.txState = jvpw_pkg::T_IDLE;
    endcase
    if (abortTx || !s_q.ctrl[jvpw_pkg::CTRL_EN_BIT]) begin
      s_d.busTxOut = 1'b0;
      s_d.txState = jvpw_pkg::T_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.ctrl <= jvpw_pkg::CTRL_RST;
      s_q.acceptMask <= jvpw_pkg::FILTER_RST;
      s_q.busIdle <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign prdata   = s_q.prdata;
  assign pready   = s_q.pready;
  assign pslverr  = s_q.pslverr;
  assign busTxOut = s_q.busTxOut;

endmodule : jvpw_codec

// ---- logic/jvpw_filter.sv ----
// Purpose: Polarity select and digital glitch filter on the receive pin.
// Assumes: rawIn is synchronous to clk.
// Notes:   Adds a fixed delay of FILT_LEN ticks to every edge.
`timescale 1ns/1ps
module jvpw_filter (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic ce,
  input  wire logic tick,
  input  wire logic rawIn,
  input  wire logic invert,
  output logic      level,
  output logic      edgePulse
);

  typedef struct packed {
    logic [3:0] cnt;
    logic       level;
    logic       edgePulse;
  } jvpw_filt_state_t;

  jvpw_filt_state_t s_q;
  jvpw_filt_state_t s_d;
  logic             inLvl;

  always_comb begin
    s_d = s_q;
    s_d.edgePulse = 1'b0;
    inLvl = rawIn ^ invert;
    if (inLvl == s_q.level) begin
      s_d.cnt = 4'h0;
    end else if (tick) begin
      if (s_q.cnt == jvpw_pkg::FILT_LEN - 4'h1) begin
        s_d.cnt = 4'h0;
        s_d.level = inLvl;
        s_d.edgePulse = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign level     = s_q.level;
  assign edgePulse = s_q.edgePulse;

endmodule : jvpw_filter
